// >>> rtps_pkg.sv
package rtps_pkg;

	// ----------------------------------------
	// Register byte addresses (word aligned)
	// ----------------------------------------
	localparam logic [7:0] ADDR_DRV_CTRL = 8'h14 << 2;
	localparam logic [7:0] ADDR_MOD_CTRL = 8'h15 << 2;
	localparam logic [7:0] ADDR_TX_SEL   = 8'h16 << 2;
	localparam logic [7:0] ADDR_RX_SEL   = 8'h17 << 2;
	localparam logic [7:0] ADDR_STATUS   = 8'h1f << 2;

	// ----------------------------------------
	// Reset values and writable masks
	// ----------------------------------------
	localparam logic [7:0] RST_DRV_CTRL  = 8'h80;
	localparam logic [7:0] RST_MOD_CTRL  = 8'h00;
	localparam logic [7:0] RST_TX_SEL    = 8'h10;
	localparam logic [7:0] RST_RX_SEL    = 8'h84;
	localparam logic [7:0] MASK_DRV_CTRL = 8'hfb;
	localparam logic [7:0] MASK_MOD_CTRL = 8'h40;
	localparam logic [7:0] MASK_TX_SEL   = 8'h3f;
	localparam logic [7:0] MASK_RX_SEL   = 8'hff;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int DRV2_INV_ON_BIT  = 7;
	localparam int DRV1_INV_ON_BIT  = 6;
	localparam int DRV2_INV_OFF_BIT = 5;
	localparam int DRV1_INV_OFF_BIT = 4;
	localparam int DRV2_CW_BIT      = 3;
	localparam int DRV2_EN_BIT      = 1;
	localparam int DRV1_EN_BIT      = 0;
	localparam int FORCE_ASK_BIT    = 6;
	localparam int DRV_SRC_LSB      = 4;
	localparam int AUX_SEL_LSB      = 0;
	localparam int RX_IN_LSB        = 6;
	localparam int GUARD_LSB        = 0;

	// ----------------------------------------
	// Field codes
	// ----------------------------------------
	localparam logic [1:0] DRV_TRISTATE = 2'h0;
	localparam logic [1:0] DRV_ENCODER  = 2'h1;
	localparam logic [1:0] DRV_AUX_IN   = 2'h2;
	localparam logic [1:0] DRV_HIGH     = 2'h3;
	localparam logic [3:0] AUX_TRI      = 4'h0;
	localparam logic [3:0] AUX_LOW      = 4'h1;
	localparam logic [3:0] AUX_HIGH     = 4'h2;
	localparam logic [3:0] AUX_TESTBUS  = 4'h3;
	localparam logic [3:0] AUX_ENVELOPE = 4'h4;
	localparam logic [3:0] AUX_TX_SER   = 4'h5;
	localparam logic [3:0] AUX_RX_SER   = 4'h7;
	localparam logic [1:0] RXI_LOW      = 2'h0;
	localparam logic [1:0] RXI_MANCH    = 2'h1;
	localparam logic [1:0] RXI_ANALOG   = 2'h2;
	localparam logic [1:0] RXI_NRZ      = 2'h3;

endpackage

// >>> rtps_guard_if.sv
`timescale 1ns/1ns
`default_nettype none
interface rtps_guard_if;
	logic       tx_done;
	logic       skip;
	logic       field_on;
	logic       bit_tick;
	logic [5:0] guard_len;
	logic       rx_active;
	logic       busy;

	modport ctl (output tx_done, skip, field_on, bit_tick, guard_len, input rx_active, busy);
	modport tmr (input tx_done, skip, field_on, bit_tick, guard_len, output rx_active, busy);
endinterface
`default_nettype wire

// >>> rtps_guard.sv
`timescale 1ns/1ns
`default_nettype none
module rtps_guard
	import rtps_pkg::*;
(
	// Clock and reset
	input  wire logic clk_i,
	input  wire logic rst_i,
	// Control side
	rtps_guard_if.tmr g
);
	logic [5:0] cnt_q;
	logic       run_q;

	// ----------------------------------------
	// Guard counter
	// ----------------------------------------
	// A field switch-on also arms the count so the receiver stays deaf while the field settles.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt_q <= 6'h00;
			run_q <= 1'b0;
		end else if ((g.tx_done && !g.skip) || g.field_on) begin
			cnt_q <= g.guard_len;
			run_q <= (g.guard_len != 6'h00);
		end else if (g.tx_done) begin
			cnt_q <= 6'h00;
			run_q <= 1'b0;
		end else if (run_q && g.bit_tick) begin
			cnt_q <= cnt_q - 6'h01;
			run_q <= (cnt_q != 6'h01);
		end
	end

	assign g.busy      = run_q;
	assign g.rx_active = !run_q;

	a_guard_load: assert property (@(posedge clk_i) disable iff (rst_i)
		(g.tx_done && !g.skip && g.guard_len != 6'h00 && !g.field_on)
		|=> run_q && cnt_q == $past(g.guard_len))
		else $error("guard delay not loaded after transmission");
	a_guard_skip: assert property (@(posedge clk_i) disable iff (rst_i)
		(g.tx_done && g.skip && !g.field_on) |=> !run_q)
		else $error("receive-only command did not skip guard");
	a_guard_field: assert property (@(posedge clk_i) disable iff (rst_i)
		(g.field_on && g.guard_len != 6'h00) |=> run_q)
		else $error("guard not started on field switch-on");
endmodule
`default_nettype wire

// >>> rtps_path_select.sv
// What this block does
// - Enabled driver 2 inverted when bit7 set
// - Enabled driver 1 inverted when bit6 set
// - Disabled driver 2 level inverted by bit5
// - Disabled driver 1 level inverted by bit4
// - Continuous-wave bit sends unmodulated carrier on driver 2
// - Continuous-wave clear modulates driver 2 carrier
// - Enable bit1 gives modulated carrier on driver 2
// - Enable bit0 gives modulated carrier on driver 1
// - Force bit gives full-depth amplitude keying
// - Source code 00 tri-states both drivers
// - Source codes pick encoder, aux input, high
// - Aux output: tri-state, low, high codes
// - Aux code 0011 routes selected test bus bit
// - Aux codes route envelope or pre-encoder stream
// - Aux code 0111 routes decoded receive stream
// - Receiver input: low or aux Manchester
// - Receiver input default: analog front end
// - Receiver code 11 takes aux NRZ data
// - Guard delay blocks receiver after transmission
// - Receive-only command skips the guard delay
// - Guard count starts at field switch-on
//
// Chosen here: the Wishbone register port.
`timescale 1ns/1ns
`default_nettype none
module rtps_path_select
	import rtps_pkg::*;
(
	// Clock and reset
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	// Wishbone slave
	input  wire logic       cyc_i,
	input  wire logic       stb_i,
	input  wire logic       we_i,
	input  wire logic [7:0] adr_i,
	input  wire logic [3:0] sel_i,
	input  wire logic [31:0] dat_i,
	output logic [31:0]     dat_o,
	output logic            ack_o,
	// Internal signal sources
	input  wire logic       carrier_i,
	input  wire logic       tx_envelope_i,
	input  wire logic       tx_serial_i,
	input  wire logic       rx_decoded_i,
	input  wire logic       analog_rx_i,
	input  wire logic [7:0] test_bus_i,
	input  wire logic [2:0] test_bus_bit_select_i,
	input  wire logic       soft_power_down_i,
	// Command and timing events
	input  wire logic       tx_done_i,
	input  wire logic       receive_only_cmd_i,
	input  wire logic       bit_clock_tick_i,
	input  wire logic       ext_field_on_i,
	// Pins
	input  wire logic       aux_signal_input_i,
	output logic            antenna_driver_1_o,
	output logic            antenna_driver_1_oe_n_o,
	output logic            antenna_driver_2_o,
	output logic            antenna_driver_2_oe_n_o,
	output logic            aux_signal_output_o,
	output logic            aux_signal_output_oe_n_o,
	// Receiver and modulator side
	output logic            receiver_input_o,
	output logic            receiver_active_o,
	output logic            force_full_ask_o
);
	logic [7:0] drv_ctrl_q;
	logic [7:0] mod_ctrl_q;
	logic [7:0] tx_sel_q;
	logic [7:0] rx_sel_q;
	logic       aux_s1_q;
	logic       aux_s2_q;
	logic       req;
	logic       wr;
	logic       ack_q;
	logic [7:0] rd_d;
	logic [31:0] dat_q;
	logic [1:0] drv_src;
	logic [3:0] aux_sel;
	logic [1:0] rx_in;
	logic       drv_in;
	logic       drv_tri;
	logic       drv1_d;
	logic       drv2_d;
	logic       drv1_q;
	logic       drv2_q;
	logic       drv_tri_q;
	logic       aux_d;
	logic       aux_oe_n_d;
	logic       aux_q;
	logic       aux_oe_n_q;
	logic       rx_in_d;
	logic       rx_in_q;

	rtps_guard_if gif ();

	// ----------------------------------------
	// Register access
	// ----------------------------------------
	function automatic logic hit(input logic [7:0] a, input logic [7:0] base);
		hit = (a == base);
	endfunction

	assign req = cyc_i && stb_i && !ack_q;
	assign wr  = req && we_i && sel_i[0];

	// Only byte lane 0 carries data; other lanes are ignored on write.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			drv_ctrl_q <= RST_DRV_CTRL;
			mod_ctrl_q <= RST_MOD_CTRL;
			tx_sel_q   <= RST_TX_SEL;
			rx_sel_q   <= RST_RX_SEL;
		end else if (wr) begin
			if (hit(adr_i, ADDR_DRV_CTRL)) begin
				drv_ctrl_q <= dat_i[7:0] & MASK_DRV_CTRL;
			end
			if (hit(adr_i, ADDR_MOD_CTRL)) begin
				mod_ctrl_q <= dat_i[7:0] & MASK_MOD_CTRL;
			end
			if (hit(adr_i, ADDR_TX_SEL)) begin
				tx_sel_q <= dat_i[7:0] & MASK_TX_SEL;
			end
			if (hit(adr_i, ADDR_RX_SEL)) begin
				rx_sel_q <= dat_i[7:0] & MASK_RX_SEL;
			end
		end
	end

	always_comb begin
		rd_d = 8'h00;
		if (hit(adr_i, ADDR_DRV_CTRL)) begin
			rd_d = drv_ctrl_q;
		end else if (hit(adr_i, ADDR_MOD_CTRL)) begin
			rd_d = mod_ctrl_q;
		end else if (hit(adr_i, ADDR_TX_SEL)) begin
			rd_d = tx_sel_q;
		end else if (hit(adr_i, ADDR_RX_SEL)) begin
			rd_d = rx_sel_q;
		end else if (hit(adr_i, ADDR_STATUS)) begin
			rd_d = {6'h00, gif.busy, receiver_active_o};
		end
	end

	// One wait state keeps read data registered; unmapped addresses ack and read zero.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_q <= 1'b0;
			dat_q <= 32'h0000_0000;
		end else begin
			ack_q <= req;
			dat_q <= {24'h00_0000, rd_d};
		end
	end

	assign ack_o = ack_q;
	assign dat_o = dat_q;

	// ----------------------------------------
	// Pin synchroniser
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			aux_s1_q <= 1'b0;
			aux_s2_q <= 1'b0;
		end else begin
			aux_s1_q <= aux_signal_input_i;
			aux_s2_q <= aux_s1_q;
		end
	end

	// ----------------------------------------
	// Antenna drivers
	// ----------------------------------------
	assign drv_src = tx_sel_q[DRV_SRC_LSB +: 2];
	assign aux_sel = tx_sel_q[AUX_SEL_LSB +: 4];
	assign rx_in   = rx_sel_q[RX_IN_LSB +: 2];

	// Soft power-down does not tri-state by itself; only the source code does.
	always_comb begin
		drv_in  = 1'b0;
		drv_tri = 1'b0;
		unique case (drv_src)
			DRV_TRISTATE: drv_tri = 1'b1;
			DRV_ENCODER:  drv_in  = tx_envelope_i;
			DRV_AUX_IN:   drv_in  = aux_s2_q;
			DRV_HIGH:     drv_in  = 1'b1;
		endcase
	end

	always_comb begin
		if (drv_ctrl_q[DRV1_EN_BIT]) begin
			drv1_d = (carrier_i & drv_in) ^ drv_ctrl_q[DRV1_INV_ON_BIT];
		end else begin
			drv1_d = drv_ctrl_q[DRV1_INV_OFF_BIT];
		end
		if (!drv_ctrl_q[DRV2_EN_BIT]) begin
			drv2_d = drv_ctrl_q[DRV2_INV_OFF_BIT];
		end else if (drv_ctrl_q[DRV2_CW_BIT]) begin
			drv2_d = carrier_i ^ drv_ctrl_q[DRV2_INV_ON_BIT];
		end else begin
			drv2_d = (carrier_i & drv_in) ^ drv_ctrl_q[DRV2_INV_ON_BIT];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			drv1_q    <= 1'b0;
			drv2_q    <= 1'b0;
			drv_tri_q <= 1'b1;
		end else begin
			drv1_q    <= drv1_d;
			drv2_q    <= drv2_d;
			drv_tri_q <= drv_tri;
		end
	end

	assign antenna_driver_1_o      = drv1_q;
	assign antenna_driver_2_o      = drv2_q;
	assign antenna_driver_1_oe_n_o = drv_tri_q;
	assign antenna_driver_2_oe_n_o = drv_tri_q;
	assign force_full_ask_o        = mod_ctrl_q[FORCE_ASK_BIT];

	// ----------------------------------------
	// Auxiliary output
	// ----------------------------------------
	// Reserved codes float the pin rather than guess at a source.
	always_comb begin
		aux_d      = 1'b0;
		aux_oe_n_d = 1'b0;
		unique case (aux_sel)
			AUX_TRI:      aux_oe_n_d = 1'b1;
			AUX_LOW:      aux_d = 1'b0;
			AUX_HIGH:     aux_d = 1'b1;
			AUX_TESTBUS:  aux_d = test_bus_i[test_bus_bit_select_i];
			AUX_ENVELOPE: aux_d = tx_envelope_i;
			AUX_TX_SER:   aux_d = tx_serial_i;
			AUX_RX_SER:   aux_d = rx_decoded_i;
			default:      aux_oe_n_d = 1'b1;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			aux_q      <= 1'b0;
			aux_oe_n_q <= 1'b1;
		end else begin
			aux_q      <= aux_d;
			aux_oe_n_q <= aux_oe_n_d;
		end
	end

	assign aux_signal_output_o      = aux_q;
	assign aux_signal_output_oe_n_o = aux_oe_n_q;

	// ----------------------------------------
	// Receiver input and guard delay
	// ----------------------------------------
	always_comb begin
		rx_in_d = 1'b0;
		unique case (rx_in)
			RXI_LOW:    rx_in_d = 1'b0;
			RXI_MANCH:  rx_in_d = aux_s2_q;
			RXI_ANALOG: rx_in_d = analog_rx_i;
			RXI_NRZ:    rx_in_d = aux_s2_q;
		endcase
	end

	assign gif.tx_done   = tx_done_i;
	assign gif.skip      = receive_only_cmd_i;
	assign gif.field_on  = ext_field_on_i;
	assign gif.bit_tick  = bit_clock_tick_i;
	assign gif.guard_len = rx_sel_q[GUARD_LSB +: 6];

	rtps_guard u_guard (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.g     (gif)
	);

	// Input is forced low while the guard runs so no edge leaks into the decoder.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rx_in_q <= 1'b0;
		end else begin
			rx_in_q <= rx_in_d && gif.rx_active;
		end
	end

	assign receiver_input_o  = rx_in_q;
	assign receiver_active_o = gif.rx_active;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	a_drv_tristate: assert property (@(posedge clk_i) disable iff (rst_i)
		(drv_src == DRV_TRISTATE) |=> antenna_driver_1_oe_n_o && antenna_driver_2_oe_n_o)
		else $error("drivers not tri-stated for source code zero");
	a_pd_no_tri: assert property (@(posedge clk_i) disable iff (rst_i)
		(soft_power_down_i && drv_src != DRV_TRISTATE)
		|=> !antenna_driver_1_oe_n_o && !antenna_driver_2_oe_n_o)
		else $error("drivers floated in power-down with a source selected");
	a_drv1_off: assert property (@(posedge clk_i) disable iff (rst_i)
		!drv_ctrl_q[DRV1_EN_BIT] |=> antenna_driver_1_o == $past(drv_ctrl_q[DRV1_INV_OFF_BIT]))
		else $error("disabled driver 1 level wrong");
	a_drv2_off: assert property (@(posedge clk_i) disable iff (rst_i)
		!drv_ctrl_q[DRV2_EN_BIT] |=> antenna_driver_2_o == $past(drv_ctrl_q[DRV2_INV_OFF_BIT]))
		else $error("disabled driver 2 level wrong");
	a_drv2_cw: assert property (@(posedge clk_i) disable iff (rst_i)
		(drv_ctrl_q[DRV2_EN_BIT] && drv_ctrl_q[DRV2_CW_BIT])
		|=> antenna_driver_2_o == ($past(carrier_i) ^ $past(drv_ctrl_q[DRV2_INV_ON_BIT])))
		else $error("continuous carrier not on driver 2");
	a_drv1_high: assert property (@(posedge clk_i) disable iff (rst_i)
		(drv_ctrl_q[DRV1_EN_BIT] && drv_src == DRV_HIGH)
		|=> antenna_driver_1_o == ($past(carrier_i) ^ $past(drv_ctrl_q[DRV1_INV_ON_BIT])))
		else $error("driver 1 high source wrong");
	a_aux_tri: assert property (@(posedge clk_i) disable iff (rst_i)
		(aux_sel == AUX_TRI) |=> aux_signal_output_oe_n_o)
		else $error("aux output not released for code zero");
	a_aux_fixed: assert property (@(posedge clk_i) disable iff (rst_i)
		(aux_sel == AUX_HIGH) |=> aux_signal_output_o && !aux_signal_output_oe_n_o)
		else $error("aux output not high");
	a_aux_envelope: assert property (@(posedge clk_i) disable iff (rst_i)
		(aux_sel == AUX_ENVELOPE) |=> aux_signal_output_o == $past(tx_envelope_i))
		else $error("aux output not encoder envelope");
	a_aux_rxser: assert property (@(posedge clk_i) disable iff (rst_i)
		(aux_sel == AUX_RX_SER) |=> aux_signal_output_o == $past(rx_decoded_i))
		else $error("aux output not decoded stream");
	a_rx_low: assert property (@(posedge clk_i) disable iff (rst_i)
		(rx_in == RXI_LOW) |=> !receiver_input_o)
		else $error("receiver input not held low");
	a_rx_guard: assert property (@(posedge clk_i) disable iff (rst_i)
		gif.busy |=> !receiver_input_o)
		else $error("receive input leaked during guard");
	a_rx_analog: assert property (@(posedge clk_i) disable iff (rst_i)
		(rx_in == RXI_ANALOG && gif.rx_active) |=> receiver_input_o == $past(analog_rx_i))
		else $error("receiver not fed from analog front end");
	a_reserved_rd: assert property (@(posedge clk_i) disable iff (rst_i)
		mod_ctrl_q[7] == 1'b0 && mod_ctrl_q[5:0] == 6'h00 && drv_ctrl_q[2] == 1'b0)
		else $error("reserved bit became set");
endmodule
`default_nettype wire

// >>> rtps_pin_model.sv
`timescale 1ns/1ns
`default_nettype none
module rtps_pin_model (
	// Clock
	input  wire logic       clk_i,
	// Pins from the block: driver 1, driver 2, aux output
	input  wire logic [2:0] pin_i,
	input  wire logic [2:0] oe_n_i,
	// Level that the far side puts on the aux input pin
	input  wire logic       aux_level_i,
	// Resolved pin levels
	output logic            aux_signal_input_o,
	output logic [2:0]      level_o
);
	// ----------------------------------------
	// Pin resolution
	// ----------------------------------------
	// A released pin has no keeper, so it toggles each cycle.
	// This stops a stale value from passing for a driven one.
	logic [2:0] last_q = 3'b000;

	assign level_o = (pin_i & ~oe_n_i) | (~last_q & oe_n_i);
	assign aux_signal_input_o = aux_level_i;

	always_ff @(posedge clk_i) begin
		last_q <= level_o;
	end
endmodule
`default_nettype wire

// >>> tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top
	import rtps_pkg::*;
;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic        clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0;
	logic [7:0]  adr = 0, tbus = 0;
	logic [3:0]  sel = 0;
	logic [31:0] wdat = 0, rdat, q;
	logic        ack, carrier = 0, env = 0, ser = 0, rxdec = 0, analog = 0, aux_lvl = 0;
	logic        tx_done = 0, ronly = 0, tick = 0, fon = 0, spd = 0, aux_in, rx_in, rx_act, ask;
	logic [2:0]  tbsel = 0, pin, oe_n, lvl;
	int          miscompares = 0, tests_run = 0, cycles = 0;
	logic [7:0]  addrs [4] = '{ADDR_DRV_CTRL, ADDR_MOD_CTRL, ADDR_TX_SEL, ADDR_RX_SEL};
	logic [7:0]  masks [4] = '{MASK_DRV_CTRL, MASK_MOD_CTRL, MASK_TX_SEL, MASK_RX_SEL};
	logic [7:0]  ctrls [6] = '{8'h03, 8'hc3, 8'h30, 8'h08, 8'hcb, 8'h0b};
	logic        src, e1, e2, ea, eo;

	rtps_path_select uut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
		.adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack), .carrier_i(carrier),
		.tx_envelope_i(env), .tx_serial_i(ser), .rx_decoded_i(rxdec), .analog_rx_i(analog),
		.test_bus_i(tbus), .test_bus_bit_select_i(tbsel), .soft_power_down_i(spd),
		.tx_done_i(tx_done), .receive_only_cmd_i(ronly), .bit_clock_tick_i(tick),
		.ext_field_on_i(fon), .aux_signal_input_i(aux_in), .antenna_driver_1_o(pin[0]),
		.antenna_driver_1_oe_n_o(oe_n[0]), .antenna_driver_2_o(pin[1]),
		.antenna_driver_2_oe_n_o(oe_n[1]), .aux_signal_output_o(pin[2]),
		.aux_signal_output_oe_n_o(oe_n[2]), .receiver_input_o(rx_in),
		.receiver_active_o(rx_act), .force_full_ask_o(ask));
	rtps_pin_model pm (.clk_i(clk_i), .pin_i(pin), .oe_n_i(oe_n), .aux_level_i(aux_lvl),
		.aux_signal_input_o(aux_in), .level_o(lvl));

	always #20 clk_i = ~clk_i;

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic give_verdict();
		if (miscompares == 0 && tests_run > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask

	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// Classic cycle; waits for ack with no assumed latency.
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		@(posedge clk_i);
		cyc <= 1; stb <= 1; we <= w; adr <= a; wdat <= d; sel <= s;
		do @(posedge clk_i); while (ack !== 1'b1);
		q = rdat;
		cyc <= 0; stb <= 0; we <= 0;
	endtask

	task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] exp);
		wb(0, a, 0, 4'h1);
		check(nm, q, exp);
	endtask

	task automatic settle(input int n);
		repeat (n) @(posedge clk_i);
	endtask

	task automatic pulse(input int w);
		@(posedge clk_i);
		case (w)
			0: tx_done <= 1;
			1: tick <= 1;
			default: fon <= 1;
		endcase
		@(posedge clk_i);
		{tx_done, tick, fon} <= 3'b000;
		@(posedge clk_i);
	endtask

	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			miscompares++;
			give_verdict();
		end
	end

	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		repeat (8) @(posedge clk_i);
		rst_i <= 0;
		rd_chk("drv_ctrl", ADDR_DRV_CTRL, 32'h0000_0080);
		rd_chk("mod_ctrl", ADDR_MOD_CTRL, 32'h0000_0000);
		rd_chk("tx_sel", ADDR_TX_SEL, 32'h0000_0010);
		rd_chk("rx_sel", ADDR_RX_SEL, 32'h0000_0084);
		wb(1, 8'h60, 32'hffff_ffff, 4'h1);
		rd_chk("unmapped", 8'h60, 32'h0000_0000);
		for (int i = 0; i < 4; i++) begin
			wb(1, addrs[i], 32'hffff_ffff, 4'h1);
			rd_chk("masked", addrs[i], {24'h0, masks[i]});
		end
		settle(2);
		check("force_ask", ask, 1);
		wb(1, ADDR_RX_SEL, 32'h0000_0000, 4'h0);
		rd_chk("sel_off", ADDR_RX_SEL, 32'h0000_00ff);
		wb(1, ADDR_MOD_CTRL, 32'h0000_0000, 4'h1);
		settle(2);
		check("force_ask", ask, 0);
		tbsel <= 3'h5;
		for (int p = 0; p < 2; p++) begin
			env <= p[0]; ser <= ~p[0]; rxdec <= p[0]; tbus <= p[0] ? 8'h20 : 8'hdf;
			for (int c = 0; c < 16; c++) begin
				wb(1, ADDR_TX_SEL, 32'h0000_0010 | c, 4'h1);
				settle(3);
				eo = !(c inside {[1:5], 7});
				case (c)
					1: ea = 0;
					2: ea = 1;
					3: ea = p[0];
					4: ea = env;
					5: ea = ser;
					default: ea = rxdec;
				endcase
				check("aux_oe_n", oe_n[2], eo);
				if (!eo) check("aux_out", lvl[2], ea);
			end
		end
		for (int p = 0; p < 3; p++) begin
			carrier <= (p != 2); env <= p[0]; aux_lvl <= ~p[0]; spd <= (p == 1);
			for (int s = 0; s < 4; s++) begin
				for (int k = 0; k < 6; k++) begin
					wb(1, ADDR_TX_SEL, s << 4, 4'h1);
					wb(1, ADDR_DRV_CTRL, ctrls[k], 4'h1);
					settle(5);
					src = (s == 1) ? env : (s == 2) ? aux_lvl : 1'b1;
					e1 = ctrls[k][0] ? ((carrier & src) ^ ctrls[k][6]) : ctrls[k][4];
					e2 = ctrls[k][1] ? ((ctrls[k][3] ? carrier : carrier & src) ^ ctrls[k][7])
						: ctrls[k][5];
					check("drv_oe_n", oe_n[1:0], (s == 0) ? 2'b11 : 2'b00);
					if (s != 0) check("drv1", lvl[0], e1);
					if (s != 0) check("drv2", lvl[1], e2);
				end
			end
		end
		for (int c = 0; c < 4; c++) begin
			for (int p = 0; p < 2; p++) begin
				analog <= p[0]; aux_lvl <= ~p[0];
				wb(1, ADDR_RX_SEL, c << 6, 4'h1);
				settle(5);
				check("rx_in", rx_in, (c == 0) ? 1'b0 : (c == 2) ? analog : aux_lvl);
			end
		end
		analog <= 1;
		wb(1, ADDR_RX_SEL, 32'h0000_0083, 4'h1);
		pulse(0);
		check("rx_active", rx_act, 0);
		settle(2);
		check("rx_in_guard", rx_in, 0);
		rd_chk("status", ADDR_STATUS, 32'h0000_0002);
		pulse(1);
		pulse(1);
		check("rx_active", rx_act, 0);
		pulse(1);
		check("rx_active", rx_act, 1);
		settle(2);
		check("rx_in", rx_in, 1);
		ronly <= 1;
		pulse(0);
		ronly <= 0;
		check("rx_active", rx_act, 1);
		pulse(2);
		check("rx_active", rx_act, 0);
		repeat (3) pulse(1);
		check("rx_active", rx_act, 1);
		give_verdict();
	end
endmodule
`default_nettype wire
